// file: rtl/glue_pkg.sv
package glue_pkg;
   // ----------------------------------------
   // widths of the processor side
   // ----------------------------------------
   localparam int LO_W       = 8;  // shared address/data lines
   localparam int HI_W       = 5;  // upper address lines, bits 8 to 12
   localparam int N_OE       = 3;  // output enables, one per memory
   localparam int SYNC_W     = 3 + HI_W + LO_W;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int BIT_ELEVEN = 3;  // position of address bit 11 in upper lines
   localparam int BIT_TWELVE = 4;  // position of address bit 12 in upper lines
   localparam int POS_ASTB   = SYNC_W - 1;
   localparam int POS_DSTB   = SYNC_W - 2;
   localparam int POS_RW     = SYNC_W - 3;

   // ----------------------------------------
   // decode codes and reset values
   // ----------------------------------------
   localparam logic [1:0]      ROM_CODE   = 2'h3;  // bit12:bit11 selecting the mux rom
   localparam logic [LO_W-1:0] LO_RST     = 8'h00;
   localparam logic [HI_W-1:0] HI_RST     = 5'h00;
   localparam logic [N_OE-1:0] OE_N_RST   = 3'h7;
   localparam logic [SYNC_W-1:0] SYNC_RST = 16'h0000;
endpackage

// file: rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 8
) (
   input  wire logic         mclk,   // system clock
   input  wire logic         rst_n,  // synchronous reset, active low
   input  wire logic [W-1:0] din,    // asynchronous pin levels
   output logic      [W-1:0] dout    // levels after two flip-flops
);
   // ----------------------------------------
   // two-stage synchroniser
   // ----------------------------------------
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] sync_r;
   logic [W-1:0] sync_nxt;

   // first stage feeds only the second stage
   always_comb begin
      meta_nxt = din;
      sync_nxt = meta_r;
      if (!rst_n) begin
         meta_nxt = '0;
         sync_nxt = '0;
      end
   end

   always_ff @(posedge mclk) begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
   end

   assign dout = sync_r;
endmodule

// file: rtl/mux_bus_demux_glue.sv
`timescale 1ns/1ps
// How it works
// - mux-bus peripheral latches the low eight address bits from shared lines.
// - peripheral drives shared lines only inside its output enable window.
// - mux memory takes address on address strobe, data only under data strobe.
// - read/write line sets data direction during data strobe.
// - read-only select combines read/write with address bits eleven and twelve.
// - non-mux memory gets all address lines valid for the whole cycle.
// - demux latch captures shared lines at address strobe falling edge.
// - latched low address stays stable until address strobe rises again.
// - chip enable of each non-mux memory held low continuously.
// - each output enable derives from data strobe, active only while it is.
// - decoder gives three active-low output enables, at most one active.
module mux_bus_demux_glue (
   input  wire logic                          mclk,                   // 20 MHz system clock
   input  wire logic                          rst_n,                  // synchronous reset, active low
   input  wire logic                          address_strobe,         // processor address strobe pin
   input  wire logic                          data_strobe,            // processor data strobe pin
   input  wire logic                          rw,                     // high read, low write
   input  wire logic [glue_pkg::HI_W-1:0]     upper_addr,             // processor address bits 8..12
   input  wire logic [glue_pkg::LO_W-1:0]     shared_addr_data_lines, // multiplexed bus, sensed only
   output logic      [glue_pkg::LO_W-1:0]     lo_addr,                // demultiplexed low address
   output logic      [glue_pkg::HI_W-1:0]     hi_addr,                // registered upper address
   output logic                               upper_addr_bit_eleven,  // decoded bit 11
   output logic                               upper_addr_bit_twelve,  // decoded bit 12
   output logic                               mem_ce_n,               // chip enable, held low
   output logic      [glue_pkg::N_OE-1:0]     mem_oe_n,               // memory output enables
   output logic                               rom_sel_n,              // mux rom select, read only
   output logic                               dir_read,               // transceiver toward processor
   output logic      [glue_pkg::LO_W-1:0]     wr_data,                // data of last write
   output logic                               wr_strobe               // one-cycle pulse per write
);
   import glue_pkg::*;

   // ----------------------------------------
   // pin synchronisation
   // ----------------------------------------
   logic [SYNC_W-1:0] pins_s;
   logic              astb_s;
   logic              dstb_s;
   logic              rw_s;
   logic [HI_W-1:0]   hi_s;
   logic [LO_W-1:0]   bus_s;

   // all pins share one delay, so strobe and data stay aligned
   pin_sync #(.W(SYNC_W)) u_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .din   ({address_strobe, data_strobe, rw, upper_addr, shared_addr_data_lines}),
      .dout  (pins_s)
   );

   assign astb_s = pins_s[POS_ASTB];
   assign dstb_s = pins_s[POS_DSTB];
   assign rw_s  = pins_s[POS_RW];
   assign hi_s  = pins_s[LO_W +: HI_W];
   assign bus_s = pins_s[LO_W-1:0];

   // ----------------------------------------
   // address demultiplexing latch
   // ----------------------------------------
   logic [LO_W-1:0] lo_r;
   logic [LO_W-1:0] lo_nxt;
   logic [HI_W-1:0] hi_r;
   logic [HI_W-1:0] hi_nxt;
   logic            astb_d_r;
   logic            astb_d_nxt;
   logic            astb_fall;

   assign astb_fall = astb_d_r && !astb_s;

   // follow while strobe high, take the fall cycle, then freeze
   always_comb begin
      lo_nxt     = lo_r;
      hi_nxt     = hi_s;
      astb_d_nxt = astb_s;
      if (astb_s) begin
         lo_nxt = bus_s;
      end else if (astb_fall) begin
         lo_nxt = bus_s;
      end
      if (!rst_n) begin
         lo_nxt     = LO_RST;
         hi_nxt     = HI_RST;
         astb_d_nxt = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      lo_r     <= lo_nxt;
      hi_r     <= hi_nxt;
      astb_d_r <= astb_d_nxt;
   end

   // ----------------------------------------
   // output enable decoding
   // ----------------------------------------
   logic [N_OE-1:0] oe_n_r;
   logic [N_OE-1:0] oe_n_nxt;
   logic            rom_n_r;
   logic            rom_n_nxt;
   logic            dir_r;
   logic            dir_nxt;
   logic [1:0]      code;

   assign code = {hi_s[BIT_TWELVE], hi_s[BIT_ELEVEN]};

   // writes never enable a memory, so no read-only part fights the processor
   always_comb begin
      oe_n_nxt  = OE_N_RST;
      rom_n_nxt = 1'b1;
      dir_nxt   = dstb_s && rw_s;
      if (dstb_s && rw_s) begin
         unique case (code)
            2'h0:    oe_n_nxt = 3'h6;
            2'h1:    oe_n_nxt = 3'h5;
            2'h2:    oe_n_nxt = 3'h3;
            ROM_CODE: rom_n_nxt = 1'b0;
         endcase
      end
      if (!rst_n) begin
         oe_n_nxt  = OE_N_RST;
         rom_n_nxt = 1'b1;
         dir_nxt   = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      oe_n_r  <= oe_n_nxt;
      rom_n_r <= rom_n_nxt;
      dir_r   <= dir_nxt;
   end

   // ----------------------------------------
   // write capture
   // ----------------------------------------
   logic [LO_W-1:0] wd_r;
   logic [LO_W-1:0] wd_nxt;
   logic [LO_W-1:0] bus_d_r;
   logic [LO_W-1:0] bus_d_nxt;
   logic            dstb_d_r;
   logic            dstb_d_nxt;
   logic            rw_d_r;
   logic            rw_d_nxt;
   logic            ws_r;
   logic            ws_nxt;
   logic            dstb_fall;

   assign dstb_fall = dstb_d_r && !dstb_s;

   // previous-cycle data is taken, it was sampled with the strobe still high
   always_comb begin
      bus_d_nxt  = bus_s;
      dstb_d_nxt = dstb_s;
      rw_d_nxt  = rw_s;
      wd_nxt    = wd_r;
      ws_nxt    = 1'b0;
      if (dstb_fall && !rw_d_r) begin
         wd_nxt = bus_d_r;
         ws_nxt = 1'b1;
      end
      if (!rst_n) begin
         bus_d_nxt = LO_RST;
         dstb_d_nxt = 1'b0;
         rw_d_nxt  = 1'b1;
         wd_nxt    = LO_RST;
         ws_nxt    = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      bus_d_r <= bus_d_nxt;
      dstb_d_r <= dstb_d_nxt;
      rw_d_r  <= rw_d_nxt;
      wd_r    <= wd_nxt;
      ws_r    <= ws_nxt;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign lo_addr               = lo_r;
   assign hi_addr               = hi_r;
   assign upper_addr_bit_eleven = hi_r[BIT_ELEVEN];
   assign upper_addr_bit_twelve = hi_r[BIT_TWELVE];
   assign mem_ce_n              = 1'b0;         // access gated by output enable only
   assign mem_oe_n              = oe_n_r;
   assign rom_sel_n             = rom_n_r;
   assign dir_read              = dir_r;
   assign wr_data               = wd_r;
   assign wr_strobe             = ws_r;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   latch_capture_a: assert property (@(posedge mclk) disable iff (!rst_n)
      astb_fall |=> lo_r == $past(bus_s))
      else $error("low address not captured at strobe fall");

   latch_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (!astb_s && !astb_d_r) ##1 !astb_s |-> $stable(lo_r))
      else $error("low address moved while strobe low");

   latch_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
      astb_s |=> lo_r == $past(bus_s))
      else $error("latch not transparent while strobe high");

   oe_onehot_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $onehot0({~oe_n_r, ~rom_n_r}))
      else $error("more than one memory enabled");

   oe_needs_strobe_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (oe_n_r != OE_N_RST) |-> $past(dstb_s) && $past(rw_s))
      else $error("output enable without read data strobe");

   rom_no_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !rom_n_r |-> $past(rw_s) && $past(code) == ROM_CODE)
      else $error("rom selected on write or wrong address");

   ce_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !mem_ce_n)
      else $error("chip enable released");

   dir_match_a: assert property (@(posedge mclk) disable iff (!rst_n)
      dir_r |-> !wr_strobe && $past(dstb_s))
      else $error("direction toward processor outside read strobe");

   wr_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (dstb_fall && !rw_d_r) |=> ws_r && wd_r == $past(bus_d_r) ##1 !ws_r)
      else $error("write data not taken once at strobe fall");

   addr_hi_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ##1 hi_r == $past(hi_s))
      else $error("upper address not passed through");

   cov_read_c:  cover property (@(posedge mclk) disable iff (!rst_n) !oe_n_r[0] ##[1:20] oe_n_r[0]);
   cov_rom_c:   cover property (@(posedge mclk) disable iff (!rst_n) !rom_n_r);
   cov_write_c: cover property (@(posedge mclk) disable iff (!rst_n) ws_r);
   cov_cycle_c: cover property (@(posedge mclk) disable iff (!rst_n) astb_fall ##[1:20] dstb_fall);
endmodule

// file: sim/cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// processor side of the multiplexed bus
// ----------------------------------------
module cpu_model (
   input  wire logic       mclk,                   // system clock
   output logic            address_strobe,         // address strobe
   output logic            data_strobe,            // data strobe
   output logic            rw,                     // high read, low write
   output logic [4:0]      upper_addr,             // address bits 8..12
   output logic [7:0]      shared_addr_data_lines  // multiplexed bus
);
   // quiet bus at time zero, strobes low
   initial begin
      address_strobe = 1'b0;
      data_strobe = 1'b0;
      rw = 1'b1;
      upper_addr = 5'h00;
      shared_addr_data_lines = 8'h00;
   end

   // every change lands a fixed 2 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   // address placed before the strobe falls, held two cycles after it
   task automatic addr_phase(input logic [12:0] a, input logic rd);
      upper_addr = a[12:8];
      shared_addr_data_lines = a[7:0];
      rw = rd;
      address_strobe = 1'b1;
      tick(4);
      address_strobe = 1'b0;
      tick(2);
      // released lines show the inverse, never a stale address
      shared_addr_data_lines = ~a[7:0];
   endtask

   // strobe high with the address strobe, bus follows it (transparent view)
   task automatic drive_lo(input logic [7:0] d);
      address_strobe = 1'b1;
      shared_addr_data_lines = d;
      tick(4);
   endtask

   // write data goes on the lines as the data strobe rises; reads leave the lines alone
   task automatic data_on(input logic [7:0] d);
      if (!rw) shared_addr_data_lines = d;
      data_strobe = 1'b1;
   endtask

   // read data taken at the fall; lines held, then released
   task automatic data_off;
      data_strobe = 1'b0;
      tick(2);
      shared_addr_data_lines = ~shared_addr_data_lines;
   endtask
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import glue_pkg::*;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   // nets driven only through instance ports
   wire logic       astb_w;
   wire logic       dstb_w;
   wire logic       rw_w;
   wire logic       ce_n;
   wire logic       bit11;
   wire logic       bit12;
   wire logic       rom_n;
   wire logic       dir_rd;
   wire logic       wr_stb;
   wire logic [4:0] up_w;
   wire logic [4:0] hi_addr;
   wire logic [7:0] bus_w;
   wire logic [7:0] lo_addr;
   wire logic [7:0] wr_data;
   wire logic [2:0] oe_n;
   int          err_total = 0;
   int          n_compared = 0;

   always #25 mclk = ~mclk;

   cpu_model cpu (.mclk(mclk), .address_strobe(astb_w), .data_strobe(dstb_w), .rw(rw_w),
                  .upper_addr(up_w), .shared_addr_data_lines(bus_w));
   mux_bus_demux_glue dut (.mclk(mclk), .rst_n(rst_n), .address_strobe(astb_w), .data_strobe(dstb_w),
      .rw(rw_w), .upper_addr(up_w), .shared_addr_data_lines(bus_w), .lo_addr(lo_addr),
      .hi_addr(hi_addr), .upper_addr_bit_eleven(bit11), .upper_addr_bit_twelve(bit12),
      .mem_ce_n(ce_n), .mem_oe_n(oe_n), .rom_sel_n(rom_n), .dir_read(dir_rd),
      .wr_data(wr_data), .wr_strobe(wr_stb));

   // ----------------------------------------
   // compare and close
   // ----------------------------------------
   task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // every output but the two decoded address bits at its reset level; also run after a reset in mid-run
   task automatic reset_test;
      chk("oe_n", 13'h7, oe_n);
      chk("rom_n", 13'h1, rom_n);
      chk("dir", 13'h0, dir_rd);
      chk("ce_n", 13'h0, ce_n);
      chk("lo_addr rst", 13'h0, lo_addr);
      chk("hi_addr rst", 13'h0, hi_addr);
      chk("wr_data rst", 13'h0, wr_data);
      chk("wr_stb rst", 13'h0, wr_stb);
      $display("reset test done");
   endtask

   // latch output follows the lines while the address strobe is high
   task automatic transp_test;
      cpu.drive_lo(8'h3C);
      chk("lo_addr", 13'h3C, lo_addr);
      cpu.drive_lo(8'hC3);
      chk("lo_addr", 13'hC3, lo_addr);
      $display("transparent test done");
   endtask

   // one read per decode code; only the matching enable drops, only under the strobe
   task automatic read_test(input logic [1:0] code);
      logic [12:0] a;
      logic [2:0]  exp_oe;
      a = {code, 3'h5, 8'hA0 + {6'h00, code}};
      exp_oe = (code == 2'h3) ? 3'h7 : ~(3'h1 << code);
      cpu.addr_phase(a, 1'b1);
      cpu.tick(3);
      chk("lo_addr held", {5'h00, a[7:0]}, lo_addr);
      chk("oe_n idle", 13'h7, oe_n);
      cpu.data_on(8'h00);
      cpu.tick(4);
      chk("hi_addr", {8'h00, a[12:8]}, hi_addr);
      chk("bits", {11'h000, code}, {bit12, bit11});
      chk("oe_n", exp_oe, oe_n);
      chk("rom_n", (code == 2'h3) ? 13'h0 : 13'h1, rom_n);
      chk("dir", 13'h1, dir_rd);
      chk("ce_n", 13'h0, ce_n);
      cpu.data_off;
      cpu.tick(2);
      chk("oe_n off", 13'h7, oe_n);
      chk("dir off", 13'h0, dir_rd);
      $display("read test code %0d done", code);
   endtask

   // writes enable nothing, the written byte is captured once
   task automatic write_test(input logic [1:0] code, input logic [7:0] d);
      int i;
      cpu.addr_phase({code, 11'h123}, 1'b0);
      // let the released bus stand one cycle before write data goes on it
      cpu.tick(1);
      cpu.data_on(d);
      cpu.tick(4);
      chk("oe_n wr", 13'h7, oe_n);
      chk("rom_n wr", 13'h1, rom_n);
      chk("dir wr", 13'h0, dir_rd);
      cpu.data_off;
      for (i = 0; i < 8 && wr_stb !== 1'b1; i++)
         cpu.tick(1);
      chk("wr_stb", 13'h1, wr_stb);
      chk("wr_data", {5'h00, d}, wr_data);
      cpu.tick(1);
      chk("wr_stb end", 13'h0, wr_stb);
      $display("write test code %0d done", code);
   endtask

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      cpu.tick(3);
      reset_test();
      rst_n = 1'b1;
      cpu.tick(1);
      transp_test();
      for (int c = 0; c < 4; c++)
         read_test(c[1:0]);
      write_test(2'h3, 8'h5A);
      write_test(2'h0, 8'hA5);
      // reset in mid-run must clear captured address and write data
      rst_n = 1'b0;
      cpu.tick(3);
      reset_test();
      rst_n = 1'b1;
      cpu.tick(1);
      read_test(2'h1);
      give_verdict();
   end

   // about seventeen cycles a bus cycle; allow far more before calling a hang
   initial begin
      #200000;
      err_total++;
      give_verdict();
   end
endmodule
